// ### rtl/mpw_top.sv
// Motor PWM core: time base, period and duty double buffers, compare and dead-time pairs
`timescale 1ns/1ps
module mpw_top
    import mpw_pkg::*;
#(
    parameter int NUM_PAIRS = 4,
    parameter int CNT_W = 15,
    parameter int DUTY_W = 16,
    parameter int DT_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [mpw_pkg::ADDR_W-1:0] addr_i,
    input wire logic [mpw_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [mpw_pkg::DATA_W-1:0] rdata_o,
    output logic [NUM_PAIRS-1:0] pair_high_output_o,
    output logic [NUM_PAIRS-1:0] pair_low_output_o,
    output logic timebase_event_o
);
    import mpw_pkg::*;

    function automatic logic [ADDR_W-1:0] duty_addr(input int idx);
        duty_addr = OFS_DUTY0 + ADDR_W'(idx);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic timebase_run_bit_reg;
    logic [1:0] timebase_mode_field_reg;
    logic [1:0] input_prescale_select_reg;
    logic [3:0] match_postscale_select_reg;
    logic [CNT_W-1:0] timebase_counter_reg;
    logic count_down_flag_reg;
    logic [CNT_W-1:0] period_buf_reg;
    logic [CNT_W-1:0] period_value_reg;
    logic [DUTY_W-1:0] duty_buf_reg [NUM_PAIRS];
    logic [DUTY_W-1:0] duty_act_reg [NUM_PAIRS];
    logic [NUM_PAIRS-1:0] pair_independent_select_reg;
    logic update_inhibit_bit_reg;
    logic [DT_W-1:0] dt_a_reg;
    logic [DT_W-1:0] dt_b_reg;
    logic [NUM_PAIRS-1:0] dts_act_reg;
    logic [NUM_PAIRS-1:0] dts_inact_reg;
    logic [5:0] presc_reg;
    logic [3:0] post_reg;
    logic event_reg;
    logic event_flag_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [NUM_PAIRS-1:0] cmp_reg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire ctl_wr = wr_i && (addr_i == OFS_CTL);
    wire cnt_wr = wr_i && (addr_i == OFS_CNT);
    wire per_wr = wr_i && (addr_i == OFS_PER);
    wire cfg1_wr = wr_i && (addr_i == OFS_CFG1);
    wire cfg2_wr = wr_i && (addr_i == OFS_CFG2);
    wire dtv_wr = wr_i && (addr_i == OFS_DTV);
    wire dts_wr = wr_i && (addr_i == OFS_DTS);
    wire stat_wr = wr_i && (addr_i == OFS_STAT);

    // ------------------------------------------------------------
    // Prescaler and time base
    // ------------------------------------------------------------
    wire [5:0] pre_lim = presc_limit(input_prescale_select_reg);
    // A write in the same cycle wins over the tick so the count is left as written
    wire tick = timebase_run_bit_reg && !ctl_wr && !cnt_wr && (presc_reg == pre_lim);
    wire [5:0] presc_next = (ctl_wr || cnt_wr) ? 6'h00 :
                            (tick ? 6'h00 : (timebase_run_bit_reg ? presc_reg + 6'h01 : presc_reg));
    wire updown = timebase_mode_field_reg[1];
    wire at_per = (timebase_counter_reg == period_value_reg);
    wire at_zero = (timebase_counter_reg == '0);
    // A zero period halts the count, so no events and no period reload
    wire step = tick && (period_value_reg != '0);
    wire wrap_edge = step && !updown && at_per;
    wire turn_down = step && updown && !count_down_flag_reg && at_per;
    wire turn_up = step && updown && count_down_flag_reg && at_zero;
    wire dir_next = !updown ? 1'b0 : (turn_down ? 1'b1 : (turn_up ? 1'b0 : count_down_flag_reg));
    wire [CNT_W-1:0] cnt_next = cnt_wr ? wdata_i[CNT_W-1:0] :
                                wrap_edge ? '0 :
                                step ? (dir_next ? timebase_counter_reg - 1'b1 : timebase_counter_reg + 1'b1) :
                                timebase_counter_reg;

    // ------------------------------------------------------------
    // Events and postscaler
    // ------------------------------------------------------------
    wire post_evt = ((timebase_mode_field_reg == MODE_FREE) && wrap_edge) ||
                    ((timebase_mode_field_reg == MODE_UPDOWN) && turn_up);
    wire direct_evt = ((timebase_mode_field_reg == MODE_SINGLE) && wrap_edge) ||
                      ((timebase_mode_field_reg == MODE_DOUBLE) && (turn_up || turn_down));
    wire post_hit = post_evt && (post_reg == match_postscale_select_reg);
    wire [3:0] post_next = (ctl_wr || cnt_wr) ? 4'h0 :
                           (post_evt ? (post_hit ? 4'h0 : post_reg + 4'h1) : post_reg);
    wire event_next = post_hit || direct_evt;
    wire run_next = ctl_wr ? wdata_i[CTL_RUN_BIT] :
                    (((timebase_mode_field_reg == MODE_SINGLE) && wrap_edge) ? 1'b0 : timebase_run_bit_reg);
    // Sticky copy of the event; a new event beats a clear in the same cycle
    wire flag_next = event_next || (event_flag_reg && !(stat_wr && wdata_i[0]));

    // ------------------------------------------------------------
    // Double-buffer transfers
    // ------------------------------------------------------------
    wire per_ld = !timebase_run_bit_reg || wrap_edge || turn_up;
    wire duty_ld = (!timebase_run_bit_reg && (updown || !update_inhibit_bit_reg)) ||
                   wrap_edge || turn_up ||
                   ((timebase_mode_field_reg == MODE_DOUBLE) && turn_down);

    // ------------------------------------------------------------
    // Compare position with half-step phase
    // ------------------------------------------------------------
    // Half steps need a prescaled tick; at 1:1 the low duty bit places no extra edge
    wire phase = (input_prescale_select_reg != 2'h0) && (presc_reg > (pre_lim >> 1));
    wire [DUTY_W-1:0] pos = {timebase_counter_reg, phase};

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [DATA_W-1:0] duty_rd;
    always_comb begin
        duty_rd = '0;
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (addr_i == duty_addr(i)) begin
                duty_rd = duty_buf_reg[i];
            end
        end
    end

    wire [DATA_W-1:0] ctl_view = (DATA_W'(timebase_run_bit_reg) << CTL_RUN_BIT) |
                                 (DATA_W'(match_postscale_select_reg) << CTL_POST_LSB) |
                                 (DATA_W'(input_prescale_select_reg) << CTL_PRE_LSB) |
                                 (DATA_W'(timebase_mode_field_reg) << CTL_MODE_LSB);
    wire [DATA_W-1:0] cnt_view = (DATA_W'(count_down_flag_reg) << CNT_DIR_BIT) | DATA_W'(timebase_counter_reg);
    wire [DATA_W-1:0] dtv_view = DATA_W'(dt_a_reg) | (DATA_W'(dt_b_reg) << DTV_B_LSB);
    wire [DATA_W-1:0] dts_view = DATA_W'(dts_act_reg) | (DATA_W'(dts_inact_reg) << DTS_INACT_LSB);
    wire [DATA_W-1:0] rd_mux = (addr_i == OFS_CTL) ? ctl_view :
                               (addr_i == OFS_CNT) ? cnt_view :
                               (addr_i == OFS_PER) ? DATA_W'(period_buf_reg) :
                               (addr_i == OFS_CFG1) ? DATA_W'(pair_independent_select_reg) :
                               (addr_i == OFS_CFG2) ? DATA_W'(update_inhibit_bit_reg) :
                               (addr_i == OFS_DTV) ? dtv_view :
                               (addr_i == OFS_DTS) ? dts_view :
                               (addr_i == OFS_STAT) ? DATA_W'(event_flag_reg) :
                               duty_rd;
    wire [DATA_W-1:0] rdata_next = rd_i ? rd_mux : '0;

    // ------------------------------------------------------------
    // Time base registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timebase_run_bit_reg <= CTL_RST[CTL_RUN_BIT];
            timebase_mode_field_reg <= CTL_RST[CTL_MODE_LSB +: 2];
            input_prescale_select_reg <= CTL_RST[CTL_PRE_LSB +: 2];
            match_postscale_select_reg <= CTL_RST[CTL_POST_LSB +: 4];
            timebase_counter_reg <= '0;
            count_down_flag_reg <= 1'b0;
            presc_reg <= 6'h00;
            post_reg <= 4'h0;
        end else if (en_i) begin
            timebase_run_bit_reg <= run_next;
            if (ctl_wr) begin
                timebase_mode_field_reg <= wdata_i[CTL_MODE_LSB +: 2];
                input_prescale_select_reg <= wdata_i[CTL_PRE_LSB +: 2];
                match_postscale_select_reg <= wdata_i[CTL_POST_LSB +: 4];
            end
            timebase_counter_reg <= cnt_next;
            count_down_flag_reg <= dir_next;
            presc_reg <= presc_next;
            post_reg <= post_next;
        end
    end

    // ------------------------------------------------------------
    // Configuration, period and status registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            period_buf_reg <= PER_RST;
            period_value_reg <= PER_RST;
            pair_independent_select_reg <= '0;
            update_inhibit_bit_reg <= 1'b0;
            dt_a_reg <= DT_RST;
            dt_b_reg <= DT_RST;
            dts_act_reg <= DTS_RST[NUM_PAIRS-1:0];
            dts_inact_reg <= DTS_RST[DTS_INACT_LSB +: NUM_PAIRS];
            event_reg <= 1'b0;
            event_flag_reg <= 1'b0;
            rdata_reg <= '0;
        end else if (en_i) begin
            if (per_wr) period_buf_reg <= wdata_i[CNT_W-1:0];
            if (per_ld) period_value_reg <= period_buf_reg;
            if (cfg1_wr) pair_independent_select_reg <= wdata_i[NUM_PAIRS-1:0];
            if (cfg2_wr) update_inhibit_bit_reg <= wdata_i[0];
            if (dtv_wr) dt_a_reg <= wdata_i[DT_W-1:0];
            if (dtv_wr) dt_b_reg <= wdata_i[DTV_B_LSB +: DT_W];
            if (dts_wr) dts_act_reg <= wdata_i[NUM_PAIRS-1:0];
            if (dts_wr) dts_inact_reg <= wdata_i[DTS_INACT_LSB +: NUM_PAIRS];
            event_reg <= event_next;
            event_flag_reg <= flag_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Duty channels and output pairs
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
        wire duty_wr = wr_i && (addr_i == duty_addr(g));
        wire [CNT_W-1:0] duty_hi = duty_act_reg[g][DUTY_W-1:1];
        wire below = pos < duty_act_reg[g];
        // Level form of the center compare: on between the descending and ascending matches
        wire center = (duty_act_reg[g] != '0) && ((duty_hi == period_value_reg) || below);
        wire cmp_next = updown ? center : below;
        wire [DT_W-1:0] on_cnt = dts_act_reg[g] ? dt_b_reg : dt_a_reg;
        wire [DT_W-1:0] off_cnt = dts_inact_reg[g] ? dt_b_reg : dt_a_reg;

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                duty_buf_reg[g] <= DUTY_RST;
                duty_act_reg[g] <= DUTY_RST;
                cmp_reg[g] <= 1'b0;
            end else if (en_i) begin
                if (duty_wr) duty_buf_reg[g] <= wdata_i;
                if (duty_ld) duty_act_reg[g] <= duty_buf_reg[g];
                cmp_reg[g] <= cmp_next;
            end
        end

        mpw_deadtime #(
            .DT_W(DT_W)
        ) u_dead (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .en_i(en_i),
            .cmp_i(cmp_reg[g]),
            .indep_i(pair_independent_select_reg[g]),
            .on_cnt_i(on_cnt),
            .off_cnt_i(off_cnt),
            .high_o(pair_high_output_o[g]),
            .low_o(pair_low_output_o[g])
        );
    end

    assign rdata_o = rdata_reg;
    assign timebase_event_o = event_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_turn_down:
        assert property (en_i && turn_down |=> count_down_flag_reg && timebase_counter_reg == $past(period_value_reg) - 1'b1)
        else $error("time base did not turn downward at period");
    a_dir_readback:
        assert property (en_i && rd_i && addr_i == OFS_CNT |=> rdata_o[CNT_DIR_BIT] == $past(count_down_flag_reg))
        else $error("direction bit not seen on counter read");
    a_updown_event:
        assert property (en_i && timebase_mode_field_reg == MODE_UPDOWN && turn_up &&
                         post_reg == match_postscale_select_reg |=> timebase_event_o)
        else $error("missing up/down event at zero");
    a_postscale_quiet:
        assert property (en_i && timebase_mode_field_reg == MODE_UPDOWN && turn_up &&
                         post_reg != match_postscale_select_reg |=> !timebase_event_o)
        else $error("event escaped the postscaler");
    a_double_event:
        assert property (en_i && timebase_mode_field_reg == MODE_DOUBLE && (turn_up || turn_down) |=> timebase_event_o)
        else $error("missing double update event");
    a_prescale_clear:
        assert property (en_i && (ctl_wr || cnt_wr) |=> presc_reg == 6'h00 && post_reg == 4'h0)
        else $error("scaler counters not cleared by write");
    a_ctl_keeps_count:
        assert property (en_i && ctl_wr |=> timebase_counter_reg == $past(timebase_counter_reg))
        else $error("control write disturbed the counter");
    a_period_follow:
        assert property (en_i && !timebase_run_bit_reg |=> period_value_reg == $past(period_buf_reg))
        else $error("period not copied while stopped");
    a_single_stop:
        assert property (en_i && timebase_mode_field_reg == MODE_SINGLE && wrap_edge |=>
                         !timebase_run_bit_reg && timebase_counter_reg == '0 && timebase_event_o)
        else $error("single shot did not stop");
    a_duty_zero_off:
        assert property (en_i && duty_act_reg[0] == '0 |=> !cmp_reg[0])
        else $error("zero duty produced an active compare");
    a_edge_full_on:
        assert property (en_i && !updown && duty_act_reg[1][DUTY_W-1:1] > period_value_reg |=> cmp_reg[1])
        else $error("oversized duty did not hold output on");
    a_center_full_on:
        assert property (en_i && updown && duty_act_reg[0] != '0 &&
                         duty_act_reg[0][DUTY_W-1:1] == period_value_reg |=> cmp_reg[0])
        else $error("duty equal to period did not hold output on");

    c_updown_turn: cover property (en_i && timebase_mode_field_reg == MODE_UPDOWN && turn_up);
    c_double_match: cover property (en_i && timebase_mode_field_reg == MODE_DOUBLE && turn_down);
    c_single_end: cover property (en_i && timebase_mode_field_reg == MODE_SINGLE && wrap_edge);
endmodule

// ### rtl/mpw_pkg.sv
// Package: register map, field positions, reset values and mode codes of the PWM core
package mpw_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // Register word offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CNT = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_PER = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_DUTY0 = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CFG1 = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_CFG2 = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_DTV = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_DTS = 4'ha;
    localparam logic [ADDR_W-1:0] OFS_STAT = 4'hb;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_RUN_BIT = 15;
    localparam int CTL_POST_LSB = 4;
    localparam int CTL_PRE_LSB = 2;
    localparam int CTL_MODE_LSB = 0;
    localparam int CNT_DIR_BIT = 15;
    localparam int DTV_B_LSB = 8;
    localparam int DTS_INACT_LSB = 4;

    // ------------------------------------------------------------
    // Mode codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_FREE = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_UPDOWN = 2'h2;
    localparam logic [1:0] MODE_DOUBLE = 2'h3;
    localparam logic [DATA_W-1:0] CTL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DUTY_RST = 16'h0000;
    localparam logic [14:0] PER_RST = 15'h0000;
    localparam logic [5:0] DT_RST = 6'h00;
    localparam logic [7:0] DTS_RST = 8'hf0;

    // ------------------------------------------------------------
    // Prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
    // ------------------------------------------------------------
    localparam logic [5:0] PRE_LIM_1 = 6'h00;
    localparam logic [5:0] PRE_LIM_4 = 6'h03;
    localparam logic [5:0] PRE_LIM_16 = 6'h0f;
    localparam logic [5:0] PRE_LIM_64 = 6'h3f;

    function automatic logic [5:0] presc_limit(input logic [1:0] sel);
        case (sel)
            2'h0: presc_limit = PRE_LIM_1;
            2'h1: presc_limit = PRE_LIM_4;
            2'h2: presc_limit = PRE_LIM_16;
            default: presc_limit = PRE_LIM_64;
        endcase
    endfunction

endpackage

// ### rtl/mpw_deadtime.sv
// Dead-time unit for one complementary output pair
`timescale 1ns/1ps
module mpw_deadtime #(
    parameter int DT_W = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic cmp_i,
    input wire logic indep_i,
    input wire logic [DT_W-1:0] on_cnt_i,
    input wire logic [DT_W-1:0] off_cnt_i,
    output logic high_o,
    output logic low_o
);
    logic cmp_d_reg;
    logic [DT_W-1:0] cnt_reg;
    logic high_reg;
    logic low_reg;

    wire rise = cmp_i && !cmp_d_reg;
    wire fall = !cmp_i && cmp_d_reg;
    wire edge_seen = rise || fall;
    wire cnt_done = (cnt_reg == '0);
    wire [DT_W-1:0] cnt_next = edge_seen ? (rise ? on_cnt_i : off_cnt_i) : (cnt_done ? cnt_reg : cnt_reg - 1'b1);
    // Unless independent, both sides off at the edge; the side turning on waits for the count to expire
    wire high_next = indep_i ? cmp_i : (edge_seen ? 1'b0 : (cnt_done ? cmp_i : high_reg));
    wire low_next = indep_i ? cmp_i : (edge_seen ? 1'b0 : (cnt_done ? !cmp_i : low_reg));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_d_reg <= 1'b0;
            cnt_reg <= '0;
            high_reg <= 1'b0;
            low_reg <= 1'b0;
        end else if (en_i) begin
            cmp_d_reg <= cmp_i;
            cnt_reg <= cnt_next;
            high_reg <= high_next;
            low_reg <= low_next;
        end
    end

    assign high_o = high_reg;
    assign low_o = low_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_dead_hold:
        assert property (en_i && !indep_i && rise && on_cnt_i != '0 |=> !high_o && !low_o)
        else $error("turn-on not held off by dead time");
    a_turnoff_now:
        assert property (en_i && !indep_i && fall |=> !high_o)
        else $error("high side did not turn off at once");
    c_dead_insert: cover property (en_i && !indep_i && rise && on_cnt_i != '0 ##1 !high_o ##[1:70] high_o);
endmodule

// ### bench/mpw_gate_model.sv
// Gate driver model of the motor bridge: counts shoot-through cycles and times dead gaps
`timescale 1ns/1ps
module mpw_gate_model (
    input wire logic clk_i,
    input wire logic [3:0] high_i,
    input wire logic [3:0] low_i,
    output int fault_cnt_o,
    output int gap_high_o,
    output int gap_low_o
);
    // Cycles each leg has spent with both gates off
    int off_run [4];
    initial begin
        fault_cnt_o = 0;
        gap_high_o = 0;
        gap_low_o = 0;
        for (int i = 0; i < 4; i++) off_run[i] = 0;
    end
    // Both transistors of one leg on together shorts the supply
    always @(posedge clk_i) begin
        if ((high_i & low_i) !== 4'h0) fault_cnt_o <= fault_cnt_o + 1;
        for (int i = 0; i < 4; i++) begin
            off_run[i] <= (high_i[i] || low_i[i]) ? 0 : off_run[i] + 1;
            // Gap length is latched on the first cycle a gate comes back on
            if (high_i[i] && off_run[i] != 0) gap_high_o <= off_run[i];
            if (low_i[i] && off_run[i] != 0) gap_low_o <= off_run[i];
        end
    end
endmodule

// ### bench/motor_pwm_timebase_duty_deadtime_test.sv
// Self-checking bench of the PWM core through its register port
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module motor_pwm_timebase_duty_deadtime_test;
    import mpw_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic en_i = 1'b1;
    logic [15:0] rdata_o;
    logic [3:0] hi, lo;
    logic timebase_event_o;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    int faults, gap_hi, gap_lo;
    always #10 clk_i = ~clk_i;
    mpw_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pair_high_output_o(hi), .pair_low_output_o(lo),
        .timebase_event_o(timebase_event_o));
    mpw_gate_model bridge (.clk_i(clk_i), .high_i(hi), .low_i(lo), .fault_cnt_o(faults), .gap_high_o(gap_hi),
        .gap_low_o(gap_lo));
    task test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard well above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        @(posedge clk_i) wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
        @(posedge clk_i) rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask
    // Events are periodic, so a whole number of periods gives an exact count
    task run(input logic [15:0] ctl, input int win, input int e);
        int c;
        c = 0;
        wr(OFS_CTL, 16'h0000);
        wr(OFS_CNT, 16'h0000);
        wr(OFS_CTL, ctl);
        repeat (8) @(posedge clk_i);
        repeat (win) begin
            @(posedge clk_i);
            #1 if (timebase_event_o === 1'b1) c++;
        end
        `CHK(c, e)
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wr(OFS_CNT, 16'h8005);
        rd(OFS_CNT, 16'h0005);
        rd(4'hf, 16'h0000);
        wr(OFS_PER, 16'h0002);
        rd(OFS_PER, 16'h0002);
        // A write while the enable is low must be lost
        @(posedge clk_i) en_i <= 1'b0;
        wr(OFS_PER, 16'h0007);
        en_i <= 1'b1;
        rd(OFS_PER, 16'h0002);
        wr(OFS_DUTY0, 16'h0000);
        wr(OFS_DUTY0 + 4'h1, 16'hffff);
        run(16'h8000, 30, 10);
        #1 `CHK({hi[1:0], lo[1:0]}, 4'b1001)
        run(16'h8010, 30, 5);
        run(16'h8004, 48, 4);
        run(16'h8002, 32, 8);
        run(16'h8012, 32, 4);
        run(16'h8033, 32, 16);
        // Longer period so the single-shot wrap falls inside the counting window
        wr(OFS_PER, 16'h000f);
        run(16'h8001, 20, 1);
        rd(OFS_CTL, 16'h0001);
        rd(OFS_CNT, 16'h0000);
        // Dead times 3 and 5 on a pair that toggles every eight cycles
        wr(OFS_DTV, 16'h0503);
        wr(OFS_DUTY0 + 4'h2, 16'h0010);
        run(16'h8000, 64, 4);
        `CHK(gap_hi, 4)
        `CHK(gap_lo, 6)
        wr(OFS_DTS, 16'h000f);
        run(16'h8000, 64, 4);
        `CHK(gap_hi, 6)
        `CHK(gap_lo, 4)
        `CHK(faults, 0)
        test_done();
    end
endmodule
